// >>> rtl/cogc_cfg.svh
// constants of the clock output gating block
`ifndef COGC_CFG_SVH
`define COGC_CFG_SVH

`define COGC_NUM_OUTPUTS 9
`define COGC_SYNC_STAGES 3
`define COGC_SYS_CLOCK_MHZ 50
`define COGC_SETTLE_TIME_US 1800
`define COGC_SETTLE_CYCLES (`COGC_SETTLE_TIME_US * `COGC_SYS_CLOCK_MHZ)

// register indices, byte address is four times the index
`define COGC_CTRL0_IDX 6'h00
`define COGC_ENABLE1_IDX 6'h01
`define COGC_ENABLE2_IDX 6'h02
`define COGC_STATUS_IDX 6'h08

`define COGC_CTRL0_RST 8'h00
`define COGC_ENABLE1_RST 8'h17
`define COGC_ENABLE2_RST 8'hF8
`define COGC_TARGET_ADDR 8'hD6

// enable bit positions per output
`define COGC_EN1_OUT0 4
`define COGC_EN1_OUT1 2
`define COGC_EN1_OUT2 1
`define COGC_EN1_OUT3 0
`define COGC_EN2_OUT4 7
`define COGC_EN2_OUT5 6
`define COGC_EN2_OUT6 5
`define COGC_EN2_OUT7 4
`define COGC_EN2_OUT8 3

// status field positions
`define COGC_ST_MODE_LSB 0
`define COGC_ST_SETTLED 2
`define COGC_ST_PDMODE 3
`define COGC_ST_ACTIVE_LSB 4
`define COGC_ST_TADDR_LSB 16

`define COGC_RESP_OKAY 2'h0
`define COGC_RESP_SLVERR 2'h2

`endif

// >>> rtl/cogc_pkg.sv
// types of the clock output gating block
`default_nettype none
package cogc_pkg;

	typedef enum logic [1:0] {
		MODE_FIRST_UP = 2'b00,
		MODE_RUN = 2'b01,
		MODE_PWR_DOWN = 2'b10
	} cogc_mode_t;

	typedef struct packed {
		logic [2:0] sync;
		logic on;
		logic out;
	} cogc_slice_t;

	typedef struct packed {
		cogc_mode_t mode;
		logic [1:0] pinSync;
		logic pdMode;
		logic [16:0] settleCnt;
		logic settled;
		logic phase;
		logic oscEnable;
		logic configActive;
		logic [7:0] ctrl0;
		logic [7:0] enable1;
		logic [7:0] enable2;
		logic awready;
		logic wready;
		logic awHeld;
		logic wHeld;
		logic [5:0] wIdx;
		logic [7:0] wData;
		logic wByte;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cogc_state_t;

endpackage : cogc_pkg
`default_nettype wire

// >>> rtl/cogc_gate_slice.sv
// glitch-free gate for one output clock
`timescale 1ns/1ps
`default_nettype none
`include "cogc_cfg.svh"
module cogc_gate_slice (
	input wire logic clock, // system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic clkEn, // freezes state when low
	input wire logic srcLevel, // source clock level for the next cycle
	input wire logic enableIn, // combined enable request
	output logic gateOut, // gated output clock
	output logic activeOut // gate currently open
);
	cogc_pkg::cogc_slice_t st_reg;
	cogc_pkg::cogc_slice_t st_next;

	// sync chain, then the gate moves only in a low phase so no pulse is cut
	always_comb begin
		st_next = st_reg;
		st_next.sync = {st_reg.sync[1:0], enableIn};
		if (!srcLevel) begin
			st_next.on = st_reg.sync[`COGC_SYNC_STAGES - 1];
		end
		st_next.out = st_next.on & srcLevel; // parks low when closed
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else if (clkEn) begin
			st_reg <= st_next;
		end
	end

	assign gateOut = st_reg.out;
	assign activeOut = st_reg.on;
endmodule : cogc_gate_slice
`default_nettype wire

// >>> rtl/clock_output_gating_ctrl.sv
// output gating control of a nine-output clock fanout buffer
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cogc_cfg.svh"
module clock_output_gating_ctrl #(
	parameter int unsigned SETTLE_CYCLES = `COGC_SETTLE_CYCLES // cycles until outputs may start
) (
	// clock, reset and freeze
	input wire logic clock, // system clock, 50 MHz
	input wire logic sys_rst, // synchronous reset, high; acts as power-up
	input wire logic clkEn, // freezes all state when low
	// board pins
	input wire logic power_good_power_down_pin, // shared power-good / power-down pin
	input wire logic [8:0] oePin, // per output enable pins, active high
	// write address channel
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	// write data channel
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	// write response channel
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	// read address channel
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	// read data channel
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	// gated clocks and power state
	output logic [8:0] outClk, // gated output clocks
	output logic oscEnable, // oscillator enable
	output logic configActive // configuration logic active
);
	cogc_pkg::cogc_state_t st_reg;
	cogc_pkg::cogc_state_t st_next;
	logic [8:0] regEnable;
	logic [8:0] sliceEnable;
	logic [8:0] sliceActive;
	logic awHs;
	logic wHs;
	logic arHs;
	logic [5:0] rIdx;
	logic wMapped;
	logic [31:0] statusWord;

	// register bits mapped to outputs, 1 enables and 0 disables each one
	always_comb begin
		regEnable[0] = st_reg.enable1[`COGC_EN1_OUT0];
		regEnable[1] = st_reg.enable1[`COGC_EN1_OUT1];
		regEnable[2] = st_reg.enable1[`COGC_EN1_OUT2];
		regEnable[3] = st_reg.enable1[`COGC_EN1_OUT3];
		regEnable[4] = st_reg.enable2[`COGC_EN2_OUT4];
		regEnable[5] = st_reg.enable2[`COGC_EN2_OUT5];
		regEnable[6] = st_reg.enable2[`COGC_EN2_OUT6];
		regEnable[7] = st_reg.enable2[`COGC_EN2_OUT7];
		regEnable[8] = st_reg.enable2[`COGC_EN2_OUT8];
	end

	// both the pin and the bit must be high; either one alone stops the output
	always_comb begin
		for (int i = 0; i < `COGC_NUM_OUTPUTS; i++) begin
			sliceEnable[i] = oePin[i] & regEnable[i] & st_reg.settled
				& (st_reg.mode == cogc_pkg::MODE_RUN);
		end
	end

	// status word, a read-only view of the block's own state
	always_comb begin
		statusWord = 32'h00000000;
		statusWord[`COGC_ST_MODE_LSB +: 2] = st_reg.mode;
		statusWord[`COGC_ST_SETTLED] = st_reg.settled;
		statusWord[`COGC_ST_PDMODE] = st_reg.pdMode;
		statusWord[`COGC_ST_ACTIVE_LSB +: 9] = sliceActive;
		statusWord[`COGC_ST_TADDR_LSB +: 8] = `COGC_TARGET_ADDR;
	end

	assign awHs = s_axi_awvalid & st_reg.awready;
	assign wHs = s_axi_wvalid & st_reg.wready;
	assign arHs = s_axi_arvalid & st_reg.arready;
	assign rIdx = s_axi_araddr[7:2];
	assign wMapped = (st_reg.wIdx == `COGC_CTRL0_IDX) || (st_reg.wIdx == `COGC_ENABLE1_IDX)
		|| (st_reg.wIdx == `COGC_ENABLE2_IDX);

	// next state of mode, timing and register bus
	always_comb begin
		st_next = st_reg;
		// the pin is synchronised; a pulse shorter than one cycle may be missed
		st_next.pinSync = {st_reg.pinSync[0], power_good_power_down_pin};
		st_next.phase = ~st_reg.phase;
		case (st_reg.mode)
			cogc_pkg::MODE_FIRST_UP: begin
				// low here only holds outputs off; it is not a power-down request
				if (st_reg.pinSync[1]) begin
					st_next.mode = cogc_pkg::MODE_RUN;
					st_next.pdMode = 1'b1; // never cleared except by power-up
				end
			end
			cogc_pkg::MODE_RUN: begin
				if (!st_reg.pinSync[1]) begin
					st_next.mode = cogc_pkg::MODE_PWR_DOWN;
				end
			end
			cogc_pkg::MODE_PWR_DOWN: begin
				if (st_reg.pinSync[1]) begin
					st_next.mode = cogc_pkg::MODE_RUN; // slice gates open four to five cycles later, outputs pulse at five to six
				end
			end
			default: begin
				st_next.mode = cogc_pkg::MODE_FIRST_UP;
			end
		endcase
		st_next.oscEnable = (st_next.mode != cogc_pkg::MODE_PWR_DOWN);
		st_next.configActive = st_next.oscEnable;
		// outputs wait for the settle time, so they are stable by its end
		if (!st_reg.settled && st_reg.mode != cogc_pkg::MODE_PWR_DOWN) begin
			if (st_reg.settleCnt >= 17'(SETTLE_CYCLES - 1)) begin
				st_next.settled = 1'b1;
			end else begin
				st_next.settleCnt = st_reg.settleCnt + 17'h00001;
			end
		end
		// write address and data are taken in either order
		if (awHs) begin
			st_next.awHeld = 1'b1;
			st_next.wIdx = s_axi_awaddr[7:2];
		end
		if (wHs) begin
			st_next.wHeld = 1'b1;
			st_next.wData = s_axi_wdata[7:0];
			st_next.wByte = s_axi_wstrb[0];
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.awHeld && st_reg.wHeld && !st_reg.bvalid) begin
			st_next.awHeld = 1'b0;
			st_next.wHeld = 1'b0;
			st_next.bvalid = 1'b1;
			// configuration logic is off in power-down, so writes are refused then
			if (wMapped && st_reg.configActive) begin
				st_next.bresp = `COGC_RESP_OKAY;
				if (st_reg.wByte) begin
					case (st_reg.wIdx)
						`COGC_CTRL0_IDX: st_next.ctrl0 = st_reg.wData;
						`COGC_ENABLE1_IDX: st_next.enable1 = st_reg.wData;
						`COGC_ENABLE2_IDX: st_next.enable2 = st_reg.wData;
						default: st_next.ctrl0 = st_reg.ctrl0;
					endcase
				end
			end else begin
				st_next.bresp = `COGC_RESP_SLVERR;
			end
		end
		st_next.awready = ~st_next.awHeld & ~st_next.bvalid;
		st_next.wready = ~st_next.wHeld & ~st_next.bvalid;
		// read path, status shows the block's own state
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (arHs) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = `COGC_RESP_OKAY;
			st_next.rdata = 32'h00000000;
			case (rIdx)
				`COGC_CTRL0_IDX: st_next.rdata[7:0] = st_reg.ctrl0;
				`COGC_ENABLE1_IDX: st_next.rdata[7:0] = st_reg.enable1;
				`COGC_ENABLE2_IDX: st_next.rdata[7:0] = st_reg.enable2;
				`COGC_STATUS_IDX: st_next.rdata = statusWord;
				default: st_next.rresp = `COGC_RESP_SLVERR;
			endcase
		end
		st_next.arready = ~st_next.rvalid;
	end

	// power-up loads every register default; clkEn low freezes everything
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.mode <= cogc_pkg::MODE_FIRST_UP;
			st_reg.ctrl0 <= `COGC_CTRL0_RST;
			st_reg.enable1 <= `COGC_ENABLE1_RST;
			st_reg.enable2 <= `COGC_ENABLE2_RST;
			st_reg.oscEnable <= 1'b1;
			st_reg.configActive <= 1'b1;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
		end else if (clkEn) begin
			st_reg <= st_next;
		end
	end

	// output 0; each gate is independent, so stopping one never disturbs the rest
	cogc_gate_slice u_slice0 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.srcLevel(st_next.phase),
		.enableIn(sliceEnable[0]),
		.gateOut(outClk[0]),
		.activeOut(sliceActive[0])
	);

	// output 1
	cogc_gate_slice u_slice1 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.srcLevel(st_next.phase),
		.enableIn(sliceEnable[1]),
		.gateOut(outClk[1]),
		.activeOut(sliceActive[1])
	);

	// output 2
	cogc_gate_slice u_slice2 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.srcLevel(st_next.phase),
		.enableIn(sliceEnable[2]),
		.gateOut(outClk[2]),
		.activeOut(sliceActive[2])
	);

	// output 3
	cogc_gate_slice u_slice3 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.srcLevel(st_next.phase),
		.enableIn(sliceEnable[3]),
		.gateOut(outClk[3]),
		.activeOut(sliceActive[3])
	);

	// output 4, first one steered by the second enable register
	cogc_gate_slice u_slice4 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.srcLevel(st_next.phase),
		.enableIn(sliceEnable[4]),
		.gateOut(outClk[4]),
		.activeOut(sliceActive[4])
	);

	// output 5
	cogc_gate_slice u_slice5 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.srcLevel(st_next.phase),
		.enableIn(sliceEnable[5]),
		.gateOut(outClk[5]),
		.activeOut(sliceActive[5])
	);

	// output 6
	cogc_gate_slice u_slice6 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.srcLevel(st_next.phase),
		.enableIn(sliceEnable[6]),
		.gateOut(outClk[6]),
		.activeOut(sliceActive[6])
	);

	// output 7
	cogc_gate_slice u_slice7 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.srcLevel(st_next.phase),
		.enableIn(sliceEnable[7]),
		.gateOut(outClk[7]),
		.activeOut(sliceActive[7])
	);

	// output 8, last of the nine
	cogc_gate_slice u_slice8 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.srcLevel(st_next.phase),
		.enableIn(sliceEnable[8]),
		.gateOut(outClk[8]),
		.activeOut(sliceActive[8])
	);

	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign oscEnable = st_reg.oscEnable;
	assign configActive = st_reg.configActive;
endmodule : clock_output_gating_ctrl
`default_nettype wire

// >>> verif/cogc_chk.sv
// port assertions of the output gating block
`timescale 1ns/1ps
`default_nettype none
module cogc_chk #(
	parameter int unsigned SETTLE_CYCLES = 16 // settle count of the design
) (
	input wire logic clock, // system clock
	input wire logic sys_rst, // reset, high
	input wire logic power_good_power_down_pin, // shared pin
	input wire logic [8:0] oePin, // enable pins
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	input wire logic [8:0] outClk, // gated clocks
	input wire logic oscEnable, // oscillator enable
	input wire logic configActive // configuration active
);
	wire logic pin = power_good_power_down_pin;
	logic seenHigh;
	// the pin changes role once it was high, so remember that since power-up
	always_ff @(posedge clock) begin
		seenHigh <= sys_rst ? 1'b0 : (seenHigh | pin);
	end
	logic [16:0] upCnt;
	// cycles since power-up, saturating, so outputs can be held to the settle time
	always_ff @(posedge clock) begin
		upCnt <= sys_rst ? 17'h00000 : ((&upCnt) ? upCnt : upCnt + 17'h00001);
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_first_off: assert property (!seenHigh |-> outClk == 9'h000)
		else $error("output ran before the pin went high");
	a_first_osc: assert property (!seenHigh |-> oscEnable && configActive)
		else $error("oscillator off before the pin went high");
	a_pd_stop: assert property ((seenHigh && !pin)[*8] ##1 (seenHigh && !pin) |->
		outClk == 9'h000 && !oscEnable && !configActive)
		else $error("power-down left something running");
	a_settle_wait: assert property (upCnt < SETTLE_CYCLES |-> outClk == 9'h000)
		else $error("output ran before the settle time");
	a_pd_restart: assert property ($rose(pin) && seenHigh && oePin == 9'h1FF |-> ##[1:12] (outClk != 9'h000))
		else $error("outputs late after power-down");
	a_osc_back: assert property ((seenHigh && pin)[*6] |-> oscEnable && configActive)
		else $error("oscillator not back after power-down");
	a_no_stretch: assert property ((outClk & $past(outClk)) == 9'h000)
		else $error("stretched output pulse");
	a_b_hold: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
		else $error("write response dropped early");
	a_r_hold: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
		else $error("read data dropped early");
	for (genvar k = 0; k < 9; k++) begin : g_oe
		a_oe_stop: assert property ((!oePin[k])[*8] |-> !outClk[k])
			else $error("output ran with its pin low");
	end
endmodule : cogc_chk
bind clock_output_gating_ctrl cogc_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (.clock, .sys_rst,
	.power_good_power_down_pin, .oePin, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
	.outClk, .oscEnable, .configActive);
`default_nettype wire

// >>> verif/cogc_board.sv
// board logic driving the enable pins and the shared pin
`timescale 1ns/1ps
`default_nettype none
module cogc_board (
	input wire logic clock, // system clock
	input wire logic pgReq, // wanted shared pin level
	input wire logic [8:0] oeReq, // wanted enable levels
	output var logic pinOut, // shared pin
	output var logic [8:0] oePinOut // enable pins
);
	// pins are driven from time zero on, the weak resistor never decides
	initial begin
		pinOut = 1'b0;
		oePinOut = 9'h1FF;
	end
	// board glue registers its requests, one cycle late
	always @(posedge clock) begin
		pinOut <= pgReq;
		oePinOut <= oeReq;
	end
endmodule : cogc_board
`default_nettype wire

// >>> verif/cogc_tb.sv
// self-checking bench of the output gating block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clock = 1'b0, sys_rst = 1'b1, pgReq = 1'b0, power_good_power_down_pin, oscEnable, configActive;
	logic [8:0] oeReq = 9'h1FF, oePin, outClk;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int mismatches = 0, n_tests = 0;
	int bp[9] = '{4, 2, 1, 0, 7, 6, 5, 4, 3};
	// free-running system clock
	always #10 clock = ~clock;
	cogc_board board_u (.clock, .pgReq, .oeReq, .pinOut(power_good_power_down_pin), .oePinOut(oePin));
	clock_output_gating_ctrl #(.SETTLE_CYCLES(16)) dut_u (.clock, .sys_rst, .clkEn(1'b1),
		.power_good_power_down_pin, .oePin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .outClk, .oscEnable, .configActive);
	task automatic chk(input logic c, input string m);
		n_tests++;
		if (c !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	// bus write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 40 && s_axi_bvalid !== 1'b1; i++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk(s_axi_bvalid === 1'b1 && s_axi_bresp === er, "write response");
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 40 && s_axi_rvalid !== 1'b1; i++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rvalid === 1'b1 && s_axi_rdata === ed && s_axi_rresp === er, "read data");
	endtask : rd
	// let gating settle, then collect which outputs pulse
	task automatic watch(output logic [8:0] act);
		act = 9'h000;
		repeat (12) @(posedge clock);
		repeat (20) begin
			@(negedge clock);
			act = act | outClk;
		end
	endtask : watch
	task automatic lat(input logic [8:0] m, output int n);
		n = 0;
		while (n < 40 && (outClk & m) == 9'h000) begin
			@(negedge clock);
			n++;
		end
	endtask : lat
	task automatic t_first;
		logic [8:0] act;
		rd(8'h00, 32'h00, 2'h0);
		rd(8'h04, 32'h17, 2'h0);
		rd(8'h08, 32'hF8, 2'h0);
		rd(8'h40, 32'h00, 2'h2);
		wr(8'h00, 8'h00, 2'h0);
		watch(act);
		chk(act === 9'h000 && oscEnable === 1'b1 && configActive === 1'b1, "first-up low");
		rd(8'h20, 32'h00D60004, 2'h0);
		@(posedge clock);
		pgReq <= 1'b1;
		watch(act);
		watch(act);
		chk(act === 9'h1FF, "run all");
		rd(8'h20, 32'h00D61FFD, 2'h0);
	endtask : t_first
	// partner register adds one cycle to each latency bound
	task automatic t_pin;
		logic [8:0] act;
		int n;
		@(posedge clock);
		oeReq <= 9'h1F7;
		watch(act);
		chk(act === 9'h1F7 && outClk[3] === 1'b0, "pin gate");
		@(posedge clock);
		oeReq <= 9'h1FF;
		lat(9'h008, n);
		chk(n >= 4 && n <= 13, "pin latency");
	endtask : t_pin
	task automatic t_reg;
		logic [8:0] act;
		logic [7:0] a, d;
		for (int i = 0; i < 9; i++) begin
			a = (i < 4) ? 8'h04 : 8'h08;
			d = (i < 4) ? 8'h17 : 8'hF8;
			wr(a, d & ~(8'h01 << bp[i]), 2'h0);
			watch(act);
			chk(act === (9'h1FF & ~(9'h001 << i)), "register gate");
			wr(a, d, 2'h0);
		end
		wr(8'h40, 8'h00, 2'h2);
		wr(8'h20, 8'h00, 2'h2);
	endtask : t_reg
	task automatic t_pd;
		logic [8:0] act;
		int n;
		@(posedge clock);
		pgReq <= 1'b0;
		watch(act);
		chk(act === 9'h000 && oscEnable === 1'b0 && configActive === 1'b0, "power-down");
		rd(8'h20, 32'h00D6000E, 2'h0);
		wr(8'h04, 8'h00, 2'h2);
		@(posedge clock);
		pgReq <= 1'b1;
		lat(9'h1FF, n);
		chk(n <= 13 && oscEnable === 1'b1, "restart");
		rd(8'h04, 32'h17, 2'h0);
		wr(8'h08, 8'h00, 2'h0);
		@(posedge clock);
		sys_rst <= 1'b1;
		@(posedge clock);
		sys_rst <= 1'b0;
		rd(8'h08, 32'hF8, 2'h0);
	endtask : t_pd
	// main sequence: reset for three cycles, then the scenarios
	initial begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		t_first();
		t_pin();
		t_reg();
		t_pd();
		finish_test();
	end
	// watchdog well beyond the roughly 600 cycles of the run
	initial begin
		#100us;
		mismatches++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
